// ==== adc_device_end.sv ====
// converter end: conversion timing, mode capture and serial readout
//
// Overview of operation
// - power down from conversion end until next
// - three-wire: convert low selects, high releases
// - three-wire: msb driven as convert falls
// - host keeps convert high at least 10 ns
// - four-wire: din low selects, high releases
// - four-wire: msb driven as din falls
// - din high at convert rise: chip select
// - four-wire: convert low at least 20 ns
// - four-wire: deselect holds din high 10 ns
// - din low at convert rise: daisy chain
// - daisy chain shifts din in on sclk fall
// - next bit presented on each sclk fall
// - chip-select modes release after last bit
// - din at conversion start picks the mode
`timescale 1ns/1ns
module adc_device_end #(
    parameter int unsigned CONV_CYCLES = adc_link_pkg::CONV_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              rst_b,
    adc_link_if.device                             link,
    input  wire logic [adc_link_pkg::RESULT_W-1:0] sample_value,
    output logic                                   conv_done,
    output logic                                   powered_down,
    output logic                                   chain_mode
);
    localparam int unsigned RW = adc_link_pkg::RESULT_W;
    localparam int unsigned BW = adc_link_pkg::BITCNT_W;
    localparam int unsigned CW = adc_link_pkg::CNT_W;

    // ==========================================================
    // pin sampling
    logic [2:0] pins_s;
    logic       cnv_s;
    logic       sck_s;
    logic       din_s;
    logic       cnv_p_q;
    logic       sck_p_q;

    sig_sync #(
        .W (3)
    ) u_pin_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({link.convert_start_select, link.sclk, link.din}),
        .q     (pins_s)
    );

    assign cnv_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign din_s = pins_s[0];

    // previous synchronised levels for edge finding
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnv_p_q <= 1'b0;
            sck_p_q <= 1'b0;
        end
        else
        begin
            cnv_p_q <= cnv_s;
            sck_p_q <= sck_s;
        end
    end

    // ==========================================================
    // edge and select decode
    logic cnv_rise;
    logic sck_fall;
    logic selected;
    logic conv_end;

    adc_link_pkg::dev_state_type state_q;
    adc_link_pkg::dev_state_type state_d;
    logic [CW-1:0] conv_cnt_q;
    logic [BW-1:0] bit_cnt_q;
    logic [RW-1:0] shift_q;
    logic          chain_q;
    logic          done_q;
    logic          shift_in;
    logic          last_bit;
    logic          oe_d;

    assign cnv_rise = cnv_s & ~cnv_p_q;
    assign sck_fall = ~sck_s & sck_p_q;
    assign conv_end = (state_q == adc_link_pkg::DEV_CONV) &&
                      (conv_cnt_q == CW'(CONV_CYCLES - 1));
    // four-wire select
    // chip-select modes: convert low or din low selects; decided at the pins,
    // since the host may hold convert high well past the conversion end
    assign selected = chain_q ? ~cnv_s : ~(cnv_s & din_s);
    // frame length
    // eighteenth fall ends frame
    assign last_bit = (bit_cnt_q == BW'(RW - 1));
    // daisy shift in
    // upstream bit enters lsb
    assign shift_in = chain_q & din_s;

    // ==========================================================
    // state sequencing
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            adc_link_pkg::DEV_ACQ:
            begin
                if (cnv_rise)
                    state_d = adc_link_pkg::DEV_CONV;
            end
            adc_link_pkg::DEV_CONV:
            begin
                if (conv_end)
                    state_d = adc_link_pkg::DEV_READ;
            end
            adc_link_pkg::DEV_READ:
            begin
                if (cnv_rise)
                    state_d = adc_link_pkg::DEV_CONV;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= adc_link_pkg::DEV_ACQ;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // conversion timer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            conv_cnt_q <= '0;
        else if (state_q != adc_link_pkg::DEV_CONV)
            conv_cnt_q <= '0;
        else
            conv_cnt_q <= conv_cnt_q + CW'(1);
    end

    // ==========================================================
    // mode capture at conversion start
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chain_q <= 1'b0;
        end
        else
        begin
            if (cnv_rise)
                chain_q <= ~din_s;
        end
    end

    // ==========================================================
    // power state and completion pulse
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            powered_down <= 1'b1;
            conv_done    <= 1'b0;
        end
        else
        begin
            // auto power down
            // off through acquisition
            if (conv_end)
                powered_down <= 1'b1;
            else if (cnv_rise)
                powered_down <= 1'b0;
            conv_done <= conv_end;
        end
    end

    // ==========================================================
    // output shift register and bit count
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_q   <= '0;
            bit_cnt_q <= '0;
            done_q    <= 1'b0;
        end
        else if (conv_end)
        begin
            shift_q   <= sample_value;
            bit_cnt_q <= '0;
            done_q    <= 1'b0;
        end
        else if ((state_q == adc_link_pkg::DEV_READ) && selected && sck_fall)
        begin
            // next bit per fall
            // msb leaves, next moves up
            shift_q   <= {shift_q[RW-2:0], shift_in};
            bit_cnt_q <= last_bit ? bit_cnt_q : bit_cnt_q + BW'(1);
            // release after last
            // only chip-select modes stop
            if (last_bit && !chain_q)
                done_q <= 1'b1;
        end
    end

    // ==========================================================
    // output enable decode
    // three-wire select
    assign oe_d = (state_q == adc_link_pkg::DEV_READ) && selected &&
                  !done_q && !(sck_fall && last_bit && !chain_q);

    // ==========================================================
    // pin drivers, registered
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            link.dout_bit <= 1'b0;
            link.dout_oe  <= 1'b0;
            chain_mode    <= 1'b0;
        end
        else
        begin
            link.dout_bit <= shift_q[RW-1];
            link.dout_oe  <= oe_d;
            chain_mode    <= chain_q;
        end
    end

endmodule : adc_device_end

// ==== adc_host_end.sv ====
// host end: starts conversions and clocks results out
`timescale 1ns/1ns
module adc_host_end #(
    parameter int unsigned CHAIN_LEN = 1
) (
    input  wire logic                                        clk,
    input  wire logic                                        rst_b,
    adc_link_if.host                                         link,
    input  wire logic                                        start,
    input  wire logic [1:0]                                  mode_sel,
    output logic                                             busy,
    output logic                                             result_valid,
    output logic [adc_link_pkg::RESULT_W*CHAIN_LEN-1:0]      result_data
);
    localparam int unsigned TOTAL = adc_link_pkg::RESULT_W * CHAIN_LEN;
    localparam int unsigned NB    = $clog2(TOTAL + 1);
    localparam int unsigned CW    = adc_link_pkg::CNT_W;

    adc_link_pkg::host_state_type state_q;
    logic [CW-1:0] cnt_q;
    logic [NB-1:0] bits_q;
    logic [1:0]    mode_q;
    logic          cnv_q;
    logic          sck_q;
    logic          din_q;
    logic          dout_s;
    logic          four;
    logic          chain;
    logic          hit_low;
    logic          hit_conv;
    logic          hit_sel;
    logic          hit_half;
    logic          hit_din;

    // data pin passes two flops
    sig_sync #(
        .W (1)
    ) u_dout_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (link.dout),
        .q     (dout_s)
    );

    // ==========================================================
    // decode
    assign four     = (mode_q == adc_link_pkg::MODE_FOUR);
    assign chain    = (mode_q == adc_link_pkg::MODE_CHAIN);
    assign hit_low  = (cnt_q == CW'(adc_link_pkg::CNV_LOW_CYC - 1));
    // convert high 10 ns, covered by conversion wait
    assign hit_conv = (cnt_q == CW'(adc_link_pkg::CONV_WAIT_CYC - 1));
    assign hit_sel  = (cnt_q == CW'(adc_link_pkg::SEL_WAIT_CYC - 1));
    assign hit_half = (cnt_q == CW'(adc_link_pkg::SCLK_HALF_CYC - 1));
    assign hit_din  = (cnt_q == CW'(adc_link_pkg::DIN_HIGH_CYC - 1));

    assign link.convert_start_select = cnv_q;
    assign link.sclk                 = sck_q;
    assign link.din                  = din_q;

    // ==========================================================
    // frame sequencer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q      <= adc_link_pkg::HOST_IDLE;
            cnt_q        <= '0;
            bits_q       <= '0;
            mode_q       <= adc_link_pkg::MODE_THREE;
            cnv_q        <= 1'b0;
            sck_q        <= 1'b0;
            din_q        <= 1'b1;
            busy         <= 1'b0;
            result_valid <= 1'b0;
            result_data  <= '0;
        end
        else
        begin
            cnt_q        <= cnt_q + CW'(1);
            result_valid <= 1'b0;
            unique case (state_q)
                adc_link_pkg::HOST_IDLE:
                begin
                    if (start)
                    begin
                        mode_q  <= mode_sel;
                        cnv_q   <= 1'b0;
                        din_q   <= (mode_sel != adc_link_pkg::MODE_CHAIN);
                        busy    <= 1'b1;
                        cnt_q   <= '0;
                        state_q <= adc_link_pkg::HOST_PRE;
                    end
                end
                adc_link_pkg::HOST_PRE:
                begin
                    if (hit_low)
                    begin
                        cnv_q   <= 1'b1;
                        cnt_q   <= '0;
                        state_q <= adc_link_pkg::HOST_CONV;
                    end
                end
                adc_link_pkg::HOST_CONV:
                begin
                    if (hit_conv)
                    begin
                        if (four)
                            din_q <= 1'b0;
                        else
                            cnv_q <= 1'b0;
                        cnt_q   <= '0;
                        bits_q  <= '0;
                        state_q <= adc_link_pkg::HOST_SEL;
                    end
                end
                adc_link_pkg::HOST_SEL:
                begin
                    if (hit_sel)
                    begin
                        sck_q   <= 1'b1;
                        cnt_q   <= '0;
                        state_q <= adc_link_pkg::HOST_HIGH;
                    end
                end
                adc_link_pkg::HOST_HIGH:
                begin
                    if (hit_half)
                    begin
                        // msb first capture
                        // sample just before the fall
                        result_data <= {result_data[TOTAL-2:0], dout_s};
                        sck_q       <= 1'b0;
                        bits_q      <= bits_q + NB'(1);
                        cnt_q       <= '0;
                        state_q     <= (bits_q == NB'(TOTAL - 1)) ?
                                       adc_link_pkg::HOST_DESEL : adc_link_pkg::HOST_LOW;
                    end
                end
                adc_link_pkg::HOST_LOW:
                begin
                    if (hit_half)
                    begin
                        sck_q   <= 1'b1;
                        cnt_q   <= '0;
                        state_q <= adc_link_pkg::HOST_HIGH;
                    end
                end
                adc_link_pkg::HOST_DESEL:
                begin
                    if (four)
                        din_q <= 1'b1;
                    if (hit_din)
                    begin
                        busy         <= 1'b0;
                        result_valid <= 1'b1;
                        state_q      <= adc_link_pkg::HOST_IDLE;
                    end
                end
                default:
                    state_q <= adc_link_pkg::HOST_IDLE;
            endcase
            if (chain && state_q == adc_link_pkg::HOST_DESEL)
                din_q <= 1'b0;
        end
    end

endmodule : adc_host_end

// ==== adc_link_if.sv ====
// pin-level link between the converter end and the host end
`timescale 1ns/1ns
interface adc_link_if;
    logic convert_start_select;   // host -> device
    logic sclk;                   // host -> device
    logic din;                    // host -> device
    logic dout_bit;               // device data
    logic dout_oe;                // device drives dout when high
    logic dout;                   // resolved level, low when released

    // wire level seen by the host
    assign dout = dout_oe & dout_bit;

    modport device (
        input  convert_start_select,
        input  sclk,
        input  din,
        output dout_bit,
        output dout_oe
    );

    modport host (
        output convert_start_select,
        output sclk,
        output din,
        input  dout
    );
endinterface : adc_link_if

// ==== adc_link_pkg.sv ====
// constants and types shared by both ends of the converter link
package adc_link_pkg;

    // ==========================================================
    // data format
    localparam int unsigned RESULT_W      = 18;
    localparam int unsigned BITCNT_W      = 5;
    localparam int unsigned CNT_W         = 8;

    // ==========================================================
    // timing in ns, as specified
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CNV_HIGH_NS   = 10;
    localparam int unsigned CNV_LOW_NS    = 20;
    localparam int unsigned DIN_HIGH_NS   = 10;
    localparam int unsigned CONV_MIN_NS   = 500;
    localparam int unsigned CONV_MAX_NS   = 1300;
    localparam int unsigned SCLK_HALF_NS  = 40;

    // ==========================================================
    // timing in clk cycles (least times round up)
    localparam int unsigned CNV_HIGH_CYC  = (CNV_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNV_LOW_CYC   = (CNV_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIN_HIGH_CYC  = (DIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_CYC      = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_MARGIN   = 4;
    localparam int unsigned CONV_WAIT_CYC = (CONV_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                            + SYNC_MARGIN;
    localparam int unsigned SEL_WAIT_CYC  = 8;
    localparam int unsigned SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;

    // ==========================================================
    // host wiring modes
    localparam logic [1:0] MODE_THREE = 2'h0;
    localparam logic [1:0] MODE_FOUR  = 2'h1;
    localparam logic [1:0] MODE_CHAIN = 2'h2;

    // ==========================================================
    // state machines
    typedef enum logic [1:0] {DEV_ACQ, DEV_CONV, DEV_READ} dev_state_type;
    typedef enum logic [2:0] {HOST_IDLE, HOST_PRE, HOST_CONV, HOST_SEL,
                              HOST_HIGH, HOST_LOW, HOST_DESEL} host_state_type;

endpackage : adc_link_pkg

// ==== sar_link_assertions.sv ====
// concurrent checks on the converter link between the host end and the converter end
`timescale 1ns/1ns
module sar_link_checker #(
    parameter int unsigned CONV_CYCLES = adc_link_pkg::CONV_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic convert_start_select,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout_bit,
    input wire logic dout_oe,
    input wire logic dout
);
    // ==========================================================
    // pin history and counts since the last convert rise
    logic       sclk_q;
    logic       conv_q;
    logic       chain_q;
    logic [4:0] fall_cnt_q;
    logic [7:0] age_q;
    logic [7:0] fall_hist_q;
    wire        fall_now  = sclk_q & ~sclk;
    wire        conv_rise = ~conv_q & convert_start_select;
    wire        cs_sel    = ~convert_start_select | ~din;
    wire        ready     = (32'(age_q) >= CONV_CYCLES + 8) && (fall_cnt_q == 5'h00);

    // sampled pins, mode strap and recent serial clock falls
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_q      <= 1'b0;
            conv_q      <= 1'b0;
            chain_q     <= 1'b0;
            fall_hist_q <= 8'h00;
        end
        else
        begin
            sclk_q      <= sclk;
            conv_q      <= convert_start_select;
            chain_q     <= conv_rise ? ~din : chain_q;
            fall_hist_q <= {fall_hist_q[6:0], fall_now};
        end
    end

    // fall count saturates at 1f, which also marks no result pending
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fall_cnt_q <= 5'h1f;
            age_q      <= 8'h00;
        end
        else
        begin
            fall_cnt_q <= conv_rise ? 5'h00 : fall_cnt_q + 5'(fall_now && fall_cnt_q != 5'h1f);
            age_q      <= conv_rise ? 8'h00 : age_q + 8'(age_q != 8'hff);
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence last_fall_s;
        !chain_q && fall_now && (fall_cnt_q == 5'h11);
    endsequence

    sequence stays_released_s;
        !dout_oe [*4];
    endsequence

    a_idle_released: assert property ((convert_start_select && din) [*8] |-> !dout_oe)
        else $error("output driven while deselected");
    a_four_wire_deselect: assert property (!chain_q && convert_start_select && $rose(din) |-> ##[1:8] !dout_oe)
        else $error("output not released after deselect");
    a_msb_on_select: assert property (ready && $rose(cs_sel) |-> ##[2:8] dout_oe)
        else $error("output not enabled after select");
    a_enable_when_selected: assert property ($rose(dout_oe) |-> cs_sel)
        else $error("output enabled without select");
    a_bit_after_fall: assert property ($changed(dout_bit) && dout_oe && $past(dout_oe) |-> fall_hist_q != 8'h00)
        else $error("data bit changed without a clock fall");
    a_release_after_last: assert property (last_fall_s |-> ##[1:8] stays_released_s)
        else $error("output not released after last bit");
    a_chain_holds: assert property (chain_q && dout_oe && !convert_start_select ##1 !convert_start_select |-> dout_oe)
        else $error("chain output dropped while convert low");
    a_conv_quiet: assert property ($rose(convert_start_select) |-> ##6 (!dout_oe) [*6])
        else $error("output driven during conversion");
endmodule : sar_link_checker

// ==== sig_sync.sv ====
// two-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ns
module sig_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : sig_sync

// ==== test_sar_adc_serial_readout_modes.sv ====
// self-checking bench: host and converter ends joined, plus one converter driven directly
`timescale 1ns/1ns
module test_sar_adc_serial_readout_modes;
    localparam int unsigned CONV = 10;
    logic        clk;
    logic        rst_b;
    logic        start;
    logic [1:0]  mode_sel;
    logic        result_valid;
    logic        busy;
    logic        done_rig;
    int          done_seen;
    logic [17:0] result_data;
    logic [17:0] sample_value;
    logic [17:0] sample_rig;
    logic        powered_down;
    logic        chain_mode;
    logic        down_rig;
    logic        chain_rig;
    logic [35:0] got;
    int          err_count;
    int          cmp_count;
    int          cycles;
    adc_link_if  link_a();
    adc_link_if  link_b();

    adc_host_end #(.CHAIN_LEN(1)) adc_host_end_i (.clk(clk), .rst_b(rst_b), .link(link_a.host), .start(start),
        .mode_sel(mode_sel), .busy(busy), .result_valid(result_valid), .result_data(result_data));
    adc_device_end #(.CONV_CYCLES(CONV)) adc_device_end_i (.clk(clk), .rst_b(rst_b), .link(link_a.device),
        .sample_value(sample_value), .conv_done(), .powered_down(powered_down), .chain_mode(chain_mode));
    adc_device_end #(.CONV_CYCLES(CONV)) adc_device_end_rig_i (.clk(clk), .rst_b(rst_b), .link(link_b.device),
        .sample_value(sample_rig), .conv_done(done_rig), .powered_down(down_rig), .chain_mode(chain_rig));
    sar_link_checker #(.CONV_CYCLES(CONV)) sar_link_checker_i (.clk(clk), .rst_b(rst_b),
        .convert_start_select(link_a.convert_start_select), .sclk(link_a.sclk), .din(link_a.din),
        .dout_bit(link_a.dout_bit), .dout_oe(link_a.dout_oe), .dout(link_a.dout));

    // ==========================================================
    // compare, close and timeout
    task automatic check(input logic [35:0] seen, input logic [35:0] want, input string what);
        cmp_count++;
        if (seen !== want)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // clock and cycle ceiling
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            close_out();
        end
    end

    // completion pulses of the second converter, counted away from the launching edge
    always @(negedge clk)
        if (done_rig === 1'b1)
            done_seen++;

    // ==========================================================
    // direct drive of the second converter
    task automatic rig_convert(input logic strap);
        int seen0;
        seen0 = done_seen;
        link_b.convert_start_select = 1'b0;
        repeat (3) @(negedge clk);
        link_b.din = strap;
        @(negedge clk);
        link_b.convert_start_select = 1'b1;
        repeat (6) @(negedge clk);
        check(36'(down_rig), 36'h0, "asleep during conversion");
        repeat (CONV + 8) @(negedge clk);
        check(36'(down_rig), 36'h1, "awake after conversion");
        check(36'(done_seen - seen0), 36'h1, "one completion pulse expected");
    endtask : rig_convert

    // serial clock at 80 ns, bit sampled late in each high phase
    task automatic rig_shift(input int n, input logic [17:0] feed);
        got = '0;
        for (int i = 0; i < n; i++)
        begin
            if (i < 18)
                link_b.din = feed[17-i];
            link_b.sclk = 1'b1;
            repeat (5) @(negedge clk);
            got[35-i] = link_b.dout;
            link_b.sclk = 1'b0;
            repeat (5) @(negedge clk);
        end
    endtask : rig_shift

    // ==========================================================
    // main sequence
    initial
    begin
        logic [1:0]  modes [3];
        logic [17:0] vals [3];
        int          n;
        modes = '{adc_link_pkg::MODE_THREE, adc_link_pkg::MODE_FOUR, adc_link_pkg::MODE_CHAIN};
        vals = '{18'h3ffff, 18'h2d2b4, 18'h00001};
        rst_b = 1'b0;
        start = 1'b0;
        mode_sel = adc_link_pkg::MODE_THREE;
        sample_value = 18'h00000;
        sample_rig = 18'h25a3c;
        link_b.convert_start_select = 1'b0;
        link_b.sclk = 1'b0;
        link_b.din = 1'b1;
        err_count = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        // host conversions in each wiring mode
        for (int m = 0; m < 3; m++)
        begin
            mode_sel = modes[m];
            sample_value = vals[m];
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
            check(36'(busy), 36'h1, "busy not raised");
            n = 0;
            while (result_valid !== 1'b1 && n < 2000)
            begin
                @(negedge clk);
                n++;
            end
            check(36'(result_valid), 36'h1, "no host result in time");
            check(36'(busy), 36'h0, "busy still high");
            check(36'(result_data), 36'(vals[m]), "host result wrong");
            check(36'(chain_mode), 36'(m == 2), "mode strap wrong");
            check(36'(powered_down), 36'h1, "awake in acquisition");
            $display("test host mode %0d done", m);
        end
        // four-wire readout, then one cut short by deselect
        rig_convert(1'b1);
        check(36'(chain_rig), 36'h0, "chip-select mode not taken");
        check(36'(link_b.dout_oe), 36'h0, "driven while deselected");
        link_b.din = 1'b0;
        rig_shift(18, 18'h00000);
        check(got, {sample_rig, 18'h00000}, "four-wire frame wrong");
        @(negedge clk);
        check(36'(link_b.dout_oe), 36'h0, "held after last bit");
        link_b.din = 1'b1;
        rig_convert(1'b1);
        link_b.din = 1'b0;
        rig_shift(5, 18'h00000);
        link_b.din = 1'b1;
        repeat (6) @(negedge clk);
        check(36'(link_b.dout_oe), 36'h0, "held after deselect");
        $display("test four-wire done");
        // daisy chain: upstream bits follow the own result
        sample_rig = 18'h0c6a1;
        rig_convert(1'b0);
        check(36'(chain_rig), 36'h1, "daisy-chain mode not taken");
        link_b.convert_start_select = 1'b0;
        rig_shift(36, 18'h2b3c5);
        check(got, {sample_rig, 18'h2b3c5}, "chain frame wrong");
        $display("test daisy chain done");
        close_out();
    end
endmodule : test_sar_adc_serial_readout_modes
